/* design/serial_pins_pkg.sv */
// constants and rule notes for the serial pin interface
// Functional notes
// - read data shifts out on the data output, driven high and low.
// - data output changes only after a falling serial clock edge.
// - data input is captured on each rising serial clock edge.
// - select high means deselected and data output at high impedance.
// - deselected means standby, unless a nonvolatile write is still running.
// - select low selects the device and makes it active.
// - after power-up nothing happens before a select falling edge; here a read opcode clocked in before it still turns on the data output.
// - write-protect low blocks nonvolatile writes; all else works normally.
// - write-protect high lets every function, writes included, work normally.
// - write-protect falling while selected aborts the pending write.
// - write-protect falling after the write cycle began has no effect.
// - every byte moves most significant bit first, both directions.
package serial_pins_pkg;
    localparam int unsigned CLK_HZ         = 25_000_000;
    localparam int unsigned WRITE_TIME_US  = 5000;
    localparam int unsigned WRITE_CYCLES   = (WRITE_TIME_US * (CLK_HZ / 1_000_000));
    localparam int unsigned BYTE_BITS      = 8;
    localparam int unsigned CMD_WIDTH      = 8;
    localparam int unsigned BIT_CNT_WIDTH  = 3;
    localparam logic [7:0]  OP_WRITE_MASK  = 8'hF7;
    localparam logic [7:0]  OP_WRITE       = 8'h02;
    localparam logic [7:0]  OP_STATUS_WR   = 8'h01;
    localparam logic [7:0]  OP_READ_MASK   = 8'hF7;
    localparam logic [7:0]  OP_READ        = 8'h03;
    localparam logic [7:0]  OP_STATUS_RD   = 8'h05;
    localparam int unsigned ADDR_BYTES     = 1;
endpackage

/* design/edge_sync3.sv */
// three-flop synchroniser with agreement filter for one level
`timescale 1ns/1ps
module edge_sync3 #(
    parameter logic RESET_VALUE = 1'b0
) (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic async_i,
    output logic      level_o
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // first stage feeds only the second; level moves when stages two and three agree
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s1_r    <= RESET_VALUE;
            s2_r    <= RESET_VALUE;
            s3_r    <= RESET_VALUE;
            level_o <= RESET_VALUE;
        end else begin
            s1_r <= async_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_o <= s3_r;
            end
        end
    end
endmodule // edge_sync3

/* design/serial_pin_if.sv */
// serial slave pin interface: shifting on the link clock, write gating on clk_i
`timescale 1ns/1ps
module serial_pin_if #(
    parameter int unsigned WRITE_CYCLES = serial_pins_pkg::WRITE_CYCLES
) (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       sck_i,
    input  wire logic       select_and_watchdog_input_n_i,
    input  wire logic       sdi_i,
    output logic            sdo_o,
    output logic            sdo_oe_n_o,
    input  wire logic       write_protect_n_i,
    input  wire logic [7:0] read_data_i,
    output logic            read_req_o,
    output logic [7:0]      rx_byte_o,
    output logic            rx_valid_o,
    output logic            rx_first_o,
    output logic            write_start_o,
    output logic            write_busy_o,
    output logic            write_aborted_o,
    output logic            standby_o,
    output logic            armed_o
);
    typedef enum logic [3:0] {
        WR_IDLE    = 4'b0001,
        WR_GATHER  = 4'b0010,
        WR_PENDING = 4'b0100,
        WR_CYCLE   = 4'b1000
    } wr_state_type;

    // ---------------- link domain (serial clock) ----------------
    // select high acts as an asynchronous clear of the link counters, shifters and read flag, since the
    // serial clock stands still between frames and cannot flush state itself
    logic       sel_n;
    logic       link_clr;
    logic [2:0] bit_cnt_r;
    logic [6:0] shift_r;
    logic [7:0] byte_r;
    logic       byte_tgl_r;
    logic       first_r;
    logic       first_byte_r;
    logic       reading_r;
    logic [7:0] tx_r;
    logic       sdo_r;
    logic       load_tgl_r;

    assign sel_n = select_and_watchdog_input_n_i;
    // system reset also clears the link side: select may already be low at power-up
    assign link_clr = sel_n | reset_i;

    // capture input on every rising edge, msb first
    always_ff @(posedge sck_i or posedge link_clr) begin
        if (link_clr) begin
            bit_cnt_r <= 3'h0;
            shift_r   <= 7'h00;
        end else begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            shift_r   <= {shift_r[5:0], sdi_i};
        end
    end

    // first-byte flag: set by deselect, cleared once the first byte of the frame completes
    always_ff @(posedge sck_i or posedge link_clr) begin
        if (link_clr) begin
            first_r <= 1'b1;
        end else if (bit_cnt_r == 3'h7) begin
            first_r <= 1'b0;
        end
    end

    // byte word and toggle survive deselect so the crossing never loses one;
    // only system reset clears them, so the toggle starts equal to its synchroniser
    always_ff @(posedge sck_i or posedge reset_i) begin
        if (reset_i) begin
            byte_r       <= 8'h00;
            first_byte_r <= 1'b0;
            byte_tgl_r   <= 1'b0;
        end else if (bit_cnt_r == 3'h7 && !sel_n) begin
            byte_r       <= {shift_r, sdi_i};
            first_byte_r <= first_r;
            byte_tgl_r   <= ~byte_tgl_r;
        end
    end

    // a read opcode in the first byte switches the output on for later bytes
    always_ff @(posedge sck_i or posedge link_clr) begin
        if (link_clr) begin
            reading_r <= 1'b0;
        end else if (bit_cnt_r == 3'h7 && first_r) begin
            reading_r <= ((({shift_r, sdi_i} & serial_pins_pkg::OP_READ_MASK)
                          == serial_pins_pkg::OP_READ)
                          || ({shift_r, sdi_i} == serial_pins_pkg::OP_STATUS_RD));
        end
    end

    // output shifter moves only on falling edges, msb first
    always_ff @(negedge sck_i or posedge link_clr) begin
        if (link_clr) begin
            tx_r       <= 8'h00;
            sdo_r      <= 1'b0;
        end else if (bit_cnt_r == 3'h0) begin
            tx_r  <= {read_data_i[6:0], 1'b0};
            sdo_r <= read_data_i[7];
        end else begin
            tx_r  <= {tx_r[6:0], 1'b0};
            sdo_r <= tx_r[7];
        end
    end

    // ask the system side for the next byte once a byte boundary passes
    always_ff @(negedge sck_i or posedge reset_i) begin
        if (reset_i) begin
            load_tgl_r <= 1'b0;
        end else if (bit_cnt_r == 3'h0 && !sel_n && reading_r) begin
            load_tgl_r <= ~load_tgl_r;
        end
    end

    // push-pull drive during reads, high impedance when deselected
    assign sdo_o      = sdo_r;
    assign sdo_oe_n_o = sel_n | ~reading_r;

    // ---------------- system domain (clk_i) ----------------
    logic         sel_n_s;
    logic         wp_n_s;
    logic         tgl_s;
    logic         load_s;
    logic         sel_n_d_r;
    logic         tgl_d_r;
    logic         load_d_r;
    logic         armed_r;
    logic         cmd_ok_r;
    logic         wr_enable_r;
    logic [7:0]   rx_byte_r;
    logic         rx_valid_r;
    logic         rx_first_r;
    logic         abort_r;
    logic [31:0]  wr_cnt_r;
    wr_state_type wr_state_r;
    wr_state_type wr_state_nxt;
    logic         byte_evt;
    logic         sel_fall;
    logic         sel_rise;

    // reset low: a select already low at power-up must not look like a falling edge
    edge_sync3 #(.RESET_VALUE(1'b0)) u_sel_sync (
        .clk_i  (clk_i),
        .reset_i(reset_i),
        .async_i(sel_n),
        .level_o(sel_n_s)
    );

    edge_sync3 #(.RESET_VALUE(1'b0)) u_wp_sync (
        .clk_i  (clk_i),
        .reset_i(reset_i),
        .async_i(write_protect_n_i),
        .level_o(wp_n_s)
    );

    edge_sync3 #(.RESET_VALUE(1'b0)) u_tgl_sync (
        .clk_i  (clk_i),
        .reset_i(reset_i),
        .async_i(byte_tgl_r),
        .level_o(tgl_s)
    );

    edge_sync3 #(.RESET_VALUE(1'b0)) u_load_sync (
        .clk_i  (clk_i),
        .reset_i(reset_i),
        .async_i(load_tgl_r),
        .level_o(load_s)
    );

    // edge history of synchronised levels
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sel_n_d_r <= 1'b0;
            tgl_d_r   <= 1'b0;
            load_d_r  <= 1'b0;
        end else begin
            sel_n_d_r <= sel_n_s;
            tgl_d_r   <= tgl_s;
            load_d_r  <= load_s;
        end
    end

    assign sel_fall = sel_n_d_r & ~sel_n_s;
    assign sel_rise = ~sel_n_d_r & sel_n_s;
    assign byte_evt = (tgl_s != tgl_d_r) & armed_r;

    // nothing counts until a select falling edge after power-up
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            armed_r <= 1'b0;
        end else if (sel_fall) begin
            armed_r <= 1'b1;
        end
    end

    // byte word sampled after its toggle settled; the word was stable for at least 4 clocks
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rx_byte_r  <= 8'h00;
            rx_valid_r <= 1'b0;
            rx_first_r <= 1'b0;
        end else begin
            rx_valid_r <= byte_evt;
            if (byte_evt) begin
                rx_byte_r  <= byte_r;
                rx_first_r <= first_byte_r;
            end
        end
    end

    // decide whether the frame is a write; any data byte completes it
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cmd_ok_r <= 1'b0;
        end else if (sel_fall || sel_rise) begin
            cmd_ok_r <= 1'b0; // frame start or end: a started write is covered by the cycle state
        end else if (rx_valid_r && !rx_first_r && wr_state_r == WR_GATHER) begin
            cmd_ok_r <= 1'b1;
        end else if (rx_valid_r && rx_first_r
                     && rx_byte_r == serial_pins_pkg::OP_STATUS_WR) begin
            cmd_ok_r <= 1'b0;
        end
    end

    // write state: gather, wait for select rise, then the timed cycle
    always_comb begin
        wr_state_nxt = wr_state_r;
        case (wr_state_r)
            WR_IDLE: begin
                if (rx_valid_r && rx_first_r
                    && (((rx_byte_r & serial_pins_pkg::OP_WRITE_MASK)
                         == serial_pins_pkg::OP_WRITE)
                        || rx_byte_r == serial_pins_pkg::OP_STATUS_WR)) begin
                    wr_state_nxt = WR_GATHER;
                end
            end
            WR_GATHER: begin
                if (!wp_n_s) begin
                    wr_state_nxt = WR_IDLE;
                end else if (rx_valid_r && !rx_first_r) begin
                    wr_state_nxt = WR_PENDING;
                end else if (sel_rise) begin
                    wr_state_nxt = WR_IDLE;            // incomplete command dropped
                end
            end
            WR_PENDING: begin
                if (!wp_n_s) begin
                    wr_state_nxt = WR_IDLE;
                end else if (sel_rise) begin
                    wr_state_nxt = WR_CYCLE;
                end
            end
            WR_CYCLE: begin
                if (wr_cnt_r == 32'h0000_0001) begin
                    wr_state_nxt = WR_IDLE;            // protect ignored here
                end
            end
            default: begin
                wr_state_nxt = WR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wr_state_r <= WR_IDLE;
        end else begin
            wr_state_r <= wr_state_nxt;
        end
    end

    // write cycle timer, runs on through deselect
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wr_cnt_r <= 32'h0000_0000;
        end else if (wr_state_r == WR_PENDING && wr_state_nxt == WR_CYCLE) begin
            wr_cnt_r <= WRITE_CYCLES;
        end else if (wr_cnt_r != 32'h0000_0000) begin
            wr_cnt_r <= wr_cnt_r - 32'h0000_0001;
        end
    end

    // sticky abort report until next select falling edge; abort wins over clear
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            abort_r <= 1'b0;
        end else if ((wr_state_r == WR_GATHER || wr_state_r == WR_PENDING) && !wp_n_s) begin
            abort_r <= 1'b1;
        end else if (sel_fall) begin
            abort_r <= 1'b0;
        end
    end

    assign wr_enable_r     = cmd_ok_r;
    assign read_req_o      = (load_s != load_d_r) & armed_r;
    assign rx_byte_o       = rx_byte_r;
    assign rx_valid_o      = rx_valid_r;
    assign rx_first_o      = rx_first_r;
    assign write_start_o   = (wr_state_r == WR_PENDING) && (wr_state_nxt == WR_CYCLE);
    assign write_busy_o    = (wr_state_r == WR_CYCLE);
    assign write_aborted_o = abort_r;
    // standby while deselected and no write running
    assign standby_o       = sel_n_s & (wr_state_r != WR_CYCLE) & ~wr_enable_r;
    assign armed_o         = armed_r;
endmodule // serial_pin_if

/* bench/serial_pin_if_sva.sv */
// port assertions for the serial pin interface
`timescale 1ns/1ps
module serial_pin_if_sva #(
    parameter int unsigned WRITE_CYCLES = serial_pins_pkg::WRITE_CYCLES
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic select_and_watchdog_input_n_i,
    input wire logic write_protect_n_i,
    input wire logic sdo_oe_n_o,
    input wire logic rx_valid_o,
    input wire logic write_start_o,
    input wire logic write_busy_o,
    input wire logic write_aborted_o,
    input wire logic standby_o,
    input wire logic armed_o
);
    logic [31:0] busy_cnt_r;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // length of the running write cycle
    always_ff @(posedge clk_i) begin
        if (reset_i)
            busy_cnt_r <= '0;
        else
            busy_cnt_r <= write_busy_o ? busy_cnt_r + 1 : '0;
    end
    a_oe_off_desel: assert property (select_and_watchdog_input_n_i
        && $past(select_and_watchdog_input_n_i) |-> sdo_oe_n_o) else $error("sdo driven");
    a_rx_one_pulse: assert property (rx_valid_o |=> !rx_valid_o)
        else $error("rx pulse too long");
    a_rx_needs_arm: assert property (rx_valid_o |-> armed_o)
        else $error("byte before select edge");
    a_arm_stays: assert property (armed_o |=> armed_o) else $error("armed lost");
    a_protect_blocks: assert property ((!write_protect_n_i)[*8] |-> !write_start_o)
        else $error("write under protect");
    a_start_deselected: assert property (write_start_o |-> $past(select_and_watchdog_input_n_i)
        && $past(select_and_watchdog_input_n_i, 3)) else $error("start while selected");
    a_busy_exact_len: assert property ($fell(write_busy_o) |-> busy_cnt_r == WRITE_CYCLES)
        else $error("write cycle length");
    a_active_selected: assert property ((!select_and_watchdog_input_n_i)[*6] |-> !standby_o)
        else $error("standby while selected");
    a_busy_not_standby: assert property (write_busy_o |-> !standby_o)
        else $error("standby during write");
    a_abort_no_start: assert property (write_aborted_o |-> !write_start_o)
        else $error("aborted write started");
    c_start: cover property (write_start_o);
    c_abort: cover property (write_aborted_o);
    c_read: cover property (!sdo_oe_n_o);
endmodule // serial_pin_if_sva

bind serial_pin_if serial_pin_if_sva #(.WRITE_CYCLES(WRITE_CYCLES)) chk (.clk_i, .reset_i,
    .select_and_watchdog_input_n_i, .write_protect_n_i, .sdo_oe_n_o, .rx_valid_o,
    .write_start_o, .write_busy_o, .write_aborted_o, .standby_o, .armed_o);

/* bench/host_master.sv */
// host-side serial master model, clock idles high between frames
`timescale 1ns/1ps
module host_master (
    output logic      sck_o,
    output logic      sel_n_o,
    output logic      sdi_o,
    input  wire logic sdo_i
);
    // select starts low so a missing power-up edge can be provoked
    initial begin
        sck_o = 1'b1;
        sel_n_o = 1'b0;
        sdi_o = 1'b0;
    end
    task automatic begin_frame();
        sel_n_o = 1'b1;
        #48 sel_n_o = 1'b0; // falling edge before the operation
    endtask
    // one byte each way, 48 ns bit time
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            #24 sck_o = 1'b0;
            sdi_o = tx[i]; // msb first on the data input
            #24 rx[i] = sdo_i;
            sck_o = 1'b1;
        end
    endtask
    task automatic end_frame();
        #24 sel_n_o = 1'b1; // select held through the last bit
        sdi_o = ~sdi_o; // released line must not look held
    endtask
endmodule // host_master

/* bench/tb_top.sv */
// self-checking bench for the serial pin interface
`timescale 1ns/1ps
module tb_top;
    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        wp_n = 1'b1;
    logic [7:0]  rd_data = 8'h00;
    logic [31:0] seed = 32'h01B913F6;
    logic        sck, sel_n, sdi, sdo, sdo_oe_n, sdo_line, rx_valid, rx_first;
    logic        wstart, wbusy, waborted, standby, armed, read_req;
    int          req_count = 0;
    logic [7:0]  rx_byte;
    logic [8:0]  exp_q[$];
    logic [7:0]  wops[3] = '{8'h02, 8'h0A, 8'h01};
    logic [7:0]  rops[3] = '{8'h03, 8'h0B, 8'h05};
    int          err_count = 0;
    int          check_count = 0;
    always #20 clk_i = ~clk_i;
    assign sdo_line = sdo_oe_n ? ~sdo : sdo; // undriven line shows a wrong level
    serial_pin_if #(.WRITE_CYCLES(20)) uut (.clk_i(clk_i), .reset_i(reset_i), .sck_i(sck),
        .select_and_watchdog_input_n_i(sel_n), .sdi_i(sdi), .sdo_o(sdo),
        .sdo_oe_n_o(sdo_oe_n), .write_protect_n_i(wp_n), .read_data_i(rd_data),
        .read_req_o(read_req), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid),
        .rx_first_o(rx_first),
        .write_start_o(wstart), .write_busy_o(wbusy), .write_aborted_o(waborted),
        .standby_o(standby), .armed_o(armed));
    host_master host (.sck_o(sck), .sel_n_o(sel_n), .sdi_o(sdi), .sdo_i(sdo_line));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (!ok) begin
            err_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // each received byte against the oldest note, read requests counted; looked at
    // on the falling edge so registered outputs have settled
    always @(negedge clk_i) begin
        if (read_req === 1'b1)
            req_count++;
        if (rx_valid === 1'b1) begin
            if (exp_q.size() == 0)
                chk(1'b0, "byte without frame");
            else
                chk({rx_first, rx_byte} === exp_q.pop_front(), "rx byte");
        end
    end
    // opcode then n random bytes; drop lowers protect after the opcode
    task automatic frame(input logic [7:0] opc, input int n, input logic drop, input logic rd);
        logic [7:0] d;
        logic [7:0] r;
        int         req0;
        seed = lfsr(seed);
        req0 = req_count;
        @(posedge clk_i) rd_data <= seed[15:8];
        host.begin_frame();
        host.xfer(opc, r);
        exp_q.push_back({1'b1, opc});
        if (drop)
            @(posedge clk_i) wp_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            seed = lfsr(seed);
            d = seed[7:0];
            host.xfer(d, r);
            exp_q.push_back({1'b0, d});
            if (rd)
                chk(r === rd_data && sdo_oe_n === 1'b0, "read byte");
            chk(standby === 1'b0, "standby while selected");
        end
        host.end_frame();
        chk(req_count - req0 == (rd ? n : 0), "read request count");
    endtask
    task automatic expect_write(input logic want);
        int seen;
        seen = 0;
        repeat (10) @(negedge clk_i) seen += (wstart === 1'b1);
        chk(seen == (want ? 1 : 0), "write start count");
    endtask
    initial begin
        logic [7:0] r0;
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        host.xfer(8'h02, r0);
        host.end_frame();
        repeat (12) @(posedge clk_i);
        chk(armed === 1'b0, "armed without edge");
        $display("test powerup done");
        foreach (wops[i]) begin
            frame(wops[i], 2, 1'b0, 1'b0);
            expect_write(1'b1);
            @(posedge clk_i) wp_n <= 1'b0; // late protect ignored
            repeat (4) @(negedge clk_i);
            chk(wbusy === 1'b1 && standby === 1'b0, "busy after late protect");
            repeat (20) @(negedge clk_i);
            chk(standby === 1'b1 && sdo_oe_n === 1'b1, "idle after write");
            @(posedge clk_i) wp_n <= 1'b1;
        end
        $display("test writes done");
        @(posedge clk_i) wp_n <= 1'b0;
        foreach (rops[i])
            frame(rops[i], 2, 1'b0, 1'b1);
        frame(8'h02, 2, 1'b0, 1'b0);
        expect_write(1'b0);
        $display("test protected done");
        @(posedge clk_i) wp_n <= 1'b1;
        frame(8'h02, 2, 1'b1, 1'b0);
        expect_write(1'b0);
        chk(waborted === 1'b1, "abort flag");
        @(posedge clk_i) wp_n <= 1'b1;
        $display("test abort done");
        repeat (20) @(posedge clk_i);
        chk(exp_q.size() == 0, "bytes missing");
        summarize();
    end
    // hang guard, well beyond the expected run
    initial begin
        #100_000;
        err_count++;
        summarize();
    end
endmodule // tb_top
